// ===== hw/qdac_pkg.sv
// qdac_pkg: constants and types for the quad current converter serial control
`default_nettype none
package qdac_pkg;
  // ==========================================
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int PEC_BITS = 32;
  localparam int RW_BIT = 23;
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 4;
  localparam int NCH = 4;
  // ==========================================
  // register select field values
  localparam logic [2:0] SEL_CODE = 3'h0;
  localparam logic [2:0] SEL_GAIN = 3'h2;
  localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
  localparam logic [2:0] SEL_OFFS = 3'h4;
  localparam logic [2:0] SEL_OFFS_ALL = 3'h5;
  localparam logic [2:0] SEL_CLR = 3'h6;
  localparam logic [2:0] SEL_CTRL = 3'h7;
  // control sub-select in data bits 15:13
  localparam logic [2:0] CSUB_SLEW = 3'h0;
  localparam logic [2:0] CSUB_MAIN = 3'h1;
  localparam logic [2:0] CSUB_CHAN = 3'h2;
  localparam logic [2:0] CSUB_BOOST = 3'h3;
  localparam logic [2:0] CSUB_SOFT = 3'h4;
  localparam logic [2:0] CSUB_STAT = 3'h5;
  // ==========================================
  // field positions
  localparam int MAIN_STATRB = 12;
  localparam int MAIN_OUTALL = 11;
  localparam int MAIN_BOOSTALL = 10;
  localparam int MAIN_PEC = 9;
  localparam int CH_RANGE_LSB = 0;
  localparam int CH_EXTRES = 2;
  localparam int CH_CLREN = 3;
  localparam int CH_INTEN = 4;
  localparam int CH_BOOST = 5;
  localparam int CH_OUTPUT_DRIVE_ENABLE = 6;
  localparam int STAT_USER = 4;
  // software register: key 0xABC in bits 11:0 resets, bit 12 toggles user bit
  localparam logic [11:0] SOFT_RESET_KEY = 12'hABC;
  localparam int SOFT_TOGGLE = 12;
  // ==========================================
  // reset values
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'hFFF0;
  // ==========================================
  // host timing (kept by the host)
  localparam int MCLK_HZ = 20_000_000;
  localparam int BOOT_WAIT_US = 100;
  localparam int CAL_WAIT_US = 200;
  localparam int BOOT_WAIT_CYC = BOOT_WAIT_US * (MCLK_HZ / 1_000_000);
  localparam int CAL_WAIT_CYC = CAL_WAIT_US * (MCLK_HZ / 1_000_000);
  // ==========================================
  // types
  typedef struct packed {
    logic rw;
    logic [1:0] dev;
    logic [2:0] sel;
    logic [1:0] ch;
    logic [15:0] data;
  } qdac_frame_s;
  typedef struct packed {
    logic [1:0] range;
    logic drive_en;
    logic boost_on;
    logic [11:0] code;
  } qdac_chan_s;
endpackage
`default_nettype wire

// ===== hw/qdac_serial_ctrl.sv
// qdac_serial_ctrl: serial front end and register file of the quad current converter
// Functional notes
// - current pins stay undriven after power-up until output explicitly enabled.
// - all codes are unsigned straight binary.
// - 24-bit frame, msb first, one bit per serial clock.
// - data sampled on falling serial clock edge.
// - packet check mode adds eight check bits, 32-bit frame.
// - load strobe low during write updates channel at frame select rise.
// - strobe high: first code write per channel counts, later only readback.
// - strobe falling after frame select high moves all pending codes out.
// - current is code/4096 of 20 or 24 mA, or 16 mA plus 4 mA.
// - four channel code registers, code in bits 15 to 4.
// - four gain and four offset trims, 12 bits in 15 to 4.
// - four clear code registers, 12 bits in bits 15 to 4.
// - main control: status readback, all outputs on, all boosts on, packet check mode.
// - channel control: range, sense resistor, clear use, enable, boost, output.
// - software register: reset and user bit toggle.
// - boost control: max voltage, phase, frequency, compensation resistor.
// - four slew control registers, one per channel.
// - status shows faults and the user toggle bit.
// - a code write starts full calibration of that channel.
// - frame bit 23 zero writes, one reads addressed register.
// - select field decodes code, gain, offset, clear and control registers.
`default_nettype none
module qdac_serial_ctrl (
  input wire logic mclk, // system clock, 20 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic sclk, // serial link clock
  input wire logic sync_n, // frame select, active low
  input wire logic sdin, // serial data in
  input wire logic load_strobe_n, // load strobe, active low
  input wire logic [1:0] dev_addr, // device address straps
  input wire logic [3:0] fault_in, // fault flags from analog core
  output logic sdo, // serial readback data
  output qdac_pkg::qdac_chan_s [3:0] chan_out, // per-channel analog controls
  output logic [3:0] cal_start, // calibration start pulse per channel
  output logic [15:0] boost_cfg, // boost converter control
  output logic [3:0][15:0] slew_cfg, // slew control per channel
  output logic [15:0] main_cfg // main control register
);
  import qdac_pkg::*;

  // ==========================================
  // link domain: shift in on falling sclk
  logic [31:0] shift_q;
  logic [5:0] cnt_q;
  logic [23:0] sdo_sh_q;
  logic [23:0] rd_word_q;
  logic fresh_q;

  // frame start marker: set while select is high, cleared by the first bit
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // word and count stay put after select rises, so the system side can decode them late
  // falling edge
  always_ff @(negedge sclk) begin
    if (fresh_q) begin
      shift_q <= {31'h0, sdin};
      cnt_q <= 6'h01;
    end else begin
      shift_q <= {shift_q[30:0], sdin};
      if (cnt_q != 6'h3F) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // readback word is quiet between frames, loaded on the first bit of a frame
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      sdo_sh_q <= 24'h000000;
      sdo <= 1'b0;
    end else if (fresh_q) begin
      sdo_sh_q <= {rd_word_q[22:0], 1'b0};
      sdo <= rd_word_q[23];
    end else begin
      sdo_sh_q <= {sdo_sh_q[22:0], 1'b0};
      sdo <= sdo_sh_q[23];
    end
  end

  // ==========================================
  // pin synchronisers
  logic [1:0] sync_s1_q, sync_s2_q, ld_s1_q, ld_s2_q, ad_s1_q, ad_s2_q;
  logic [3:0] flt_s1_q, flt_s2_q;
  logic sync_s3_q, ld_s3_q;
  always_ff @(posedge mclk) begin
    sync_s1_q <= {sync_s1_q[0], sync_n};
    ld_s1_q <= {ld_s1_q[0], load_strobe_n};
    ad_s1_q <= dev_addr;
    ad_s2_q <= ad_s1_q;
    flt_s1_q <= fault_in;
    flt_s2_q <= flt_s1_q;
  end
  assign sync_s2_q = sync_s1_q;
  assign ld_s2_q = ld_s1_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync_s3_q <= 1'b1;
      // strobe edge detector starts at the pin level, so no false edge after reset
      ld_s3_q <= ld_s2_q[1];
    end else begin
      sync_s3_q <= sync_s2_q[1];
      ld_s3_q <= ld_s2_q[1];
    end
  end
  logic sync_rise, ld_fall, ld_lvl;
  assign sync_rise = sync_s2_q[1] & ~sync_s3_q;
  assign ld_fall = ~ld_s2_q[1] & ld_s3_q;
  assign ld_lvl = ld_s2_q[1];

  // ==========================================
  // frame decode (link registers are idle once select is seen high)
  qdac_frame_s frm;
  logic pec_on, frame_ok, wr_go, rd_go;
  assign pec_on = main_cfg[MAIN_PEC];
  assign frm = pec_on ? qdac_frame_s'(shift_q[31:8]) : qdac_frame_s'(shift_q[23:0]);
  assign frame_ok = (cnt_q == (pec_on ? 6'(PEC_BITS) : 6'(FRAME_BITS))) && (frm.dev == ad_s2_q);
  assign wr_go = sync_rise & frame_ok & ~frm.rw;
  assign rd_go = sync_rise & frame_ok & frm.rw;

  // ==========================================
  // register file
  logic [3:0][15:0] code_q, pend_q, gain_q, offs_q, clr_q, chctl_q, slew_q;
  logic [3:0] pend_v_q;
  logic [3:0][11:0] act_q;
  logic [15:0] boost_q, main_q, stat_q;
  logic user_q, soft_rst;
  logic [2:0] csub;
  assign csub = frm.data[15:13];
  assign soft_rst = wr_go && frm.sel == SEL_CTRL && csub == CSUB_SOFT &&
                    frm.data[11:0] == SOFT_RESET_KEY;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic hit, code_wr;
      assign hit = (frm.ch == 2'(g));
      assign code_wr = wr_go && frm.sel == SEL_CODE && hit;
      always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
          code_q[g] <= REG_RST;
          pend_q[g] <= REG_RST;
          pend_v_q[g] <= 1'b0;
          act_q[g] <= 12'h000;
          gain_q[g] <= GAIN_RST;
          offs_q[g] <= REG_RST;
          clr_q[g] <= REG_RST;
          chctl_q[g] <= REG_RST;
          slew_q[g] <= REG_RST;
          cal_start[g] <= 1'b0;
        end else begin
          cal_start[g] <= code_wr;
          // code register, latest value kept for readback
          if (code_wr) begin
            code_q[g] <= frm.data & 16'hFFF0;
          end
          if (code_wr && ld_lvl && !pend_v_q[g]) begin
            pend_q[g] <= frm.data & 16'hFFF0;
            pend_v_q[g] <= 1'b1;
          end else if (ld_fall) begin
            pend_v_q[g] <= 1'b0;
          end
          if (code_wr && !ld_lvl) begin
            act_q[g] <= frm.data[CODE_MSB:CODE_LSB];
          end else if (ld_fall && pend_v_q[g]) begin
            act_q[g] <= pend_q[g][CODE_MSB:CODE_LSB];
          end
          if (wr_go && ((frm.sel == SEL_GAIN && hit) || frm.sel == SEL_GAIN_ALL)) begin
            gain_q[g] <= frm.data & 16'hFFF0;
          end
          if (wr_go && ((frm.sel == SEL_OFFS && hit) || frm.sel == SEL_OFFS_ALL)) begin
            offs_q[g] <= frm.data & 16'hFFF0;
          end
          if (wr_go && frm.sel == SEL_CLR && hit) begin
            clr_q[g] <= frm.data & 16'hFFF0;
          end
          if (wr_go && frm.sel == SEL_CTRL && csub == CSUB_CHAN && hit) begin
            chctl_q[g] <= {3'h0, frm.data[12:0]};
          end
          if (wr_go && frm.sel == SEL_CTRL && csub == CSUB_SLEW && hit) begin
            slew_q[g] <= {3'h0, frm.data[12:0]};
          end
        end
      end
      // range field drives the analog transfer; code unsigned
      always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
          chan_out[g] <= '0;
        end else begin
          chan_out[g].range <= chctl_q[g][CH_RANGE_LSB +: 2];
          chan_out[g].drive_en <= chctl_q[g][CH_OUTPUT_DRIVE_ENABLE] | main_q[MAIN_OUTALL];
          chan_out[g].boost_on <= chctl_q[g][CH_BOOST] | main_q[MAIN_BOOSTALL];
          chan_out[g].code <= act_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rstn || soft_rst) begin
      main_q <= REG_RST;
      boost_q <= REG_RST;
    end else if (wr_go && frm.sel == SEL_CTRL) begin
      if (csub == CSUB_MAIN) begin
        main_q <= {3'h0, frm.data[12:0]};
      end
      if (csub == CSUB_BOOST) begin
        boost_q <= {3'h0, frm.data[12:0]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || soft_rst) begin
      user_q <= 1'b0;
      stat_q <= REG_RST;
    end else begin
      if (wr_go && frm.sel == SEL_CTRL && csub == CSUB_SOFT && frm.data[SOFT_TOGGLE]) begin
        user_q <= ~user_q;
      end
      stat_q <= {11'h000, user_q, flt_s2_q};
    end
  end

  // ==========================================
  // readback word, held steady for the next frame
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    case (frm.sel)
      SEL_CODE: rd_val = code_q[frm.ch];
      SEL_GAIN, SEL_GAIN_ALL: rd_val = gain_q[frm.ch];
      SEL_OFFS, SEL_OFFS_ALL: rd_val = offs_q[frm.ch];
      SEL_CLR: rd_val = clr_q[frm.ch];
      SEL_CTRL: begin
        case (csub)
          CSUB_SLEW: rd_val = slew_q[frm.ch];
          CSUB_MAIN: rd_val = main_q;
          CSUB_CHAN: rd_val = chctl_q[frm.ch];
          CSUB_BOOST: rd_val = boost_q;
          CSUB_STAT: rd_val = stat_q;
          default: rd_val = 16'h0000;
        endcase
      end
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_word_q <= 24'h000000;
    end else if (rd_go) begin
      rd_word_q <= {frm.rw, frm.dev, frm.sel, frm.ch, rd_val};
    end else if (wr_go && main_q[MAIN_STATRB]) begin
      rd_word_q <= {8'h00, stat_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      boost_cfg <= REG_RST;
      main_cfg <= REG_RST;
      slew_cfg <= '0;
    end else begin
      boost_cfg <= boost_q;
      main_cfg <= main_q;
      slew_cfg <= slew_q;
    end
  end

  // ==========================================
  // checks
  sequence s_direct_write(int c);
    wr_go && frm.sel == SEL_CODE && frm.ch == 2'(c) && ld_lvl == 1'b0;
  endsequence
  sequence s_load_fall;
    ld_fall;
  endsequence
  sequence s_status_write;
    wr_go && !rd_go && main_q[MAIN_STATRB];
  endsequence

  AST_DIRECT_UPDATE: assert property (@(posedge mclk) disable iff (!rstn)
    s_direct_write(0) |-> ##2 chan_out[0].code == $past(frm.data[CODE_MSB:CODE_LSB], 2))
    else $error("direct code write did not reach channel 0");
  AST_FIRST_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
    pend_v_q[1] && ld_lvl && !ld_fall && !soft_rst |=> $stable(pend_q[1]))
    else $error("pending code changed after first write");
  AST_SIMUL_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
    s_load_fall ##0 (pend_v_q[2] && !soft_rst && !wr_go) |=> act_q[2] == $past(pend_q[2][CODE_MSB:CODE_LSB]))
    else $error("pending code not transferred on strobe fall");
  AST_OUT_OFF: assert property (@(posedge mclk)
    $rose(rstn) |-> ##1 (chan_out[3].drive_en == 1'b0) [*2])
    else $error("output driven right after reset");
  AST_CAL_PULSE: assert property (@(posedge mclk) disable iff (!rstn || soft_rst)
    wr_go && frm.sel == SEL_CODE && frm.ch == 2'h0 |=> cal_start[0] ##1 !cal_start[0])
    else $error("calibration pulse missing");
  AST_READ_NOWRITE: assert property (@(posedge mclk) disable iff (!rstn)
    rd_go |=> $stable(code_q) && $stable(main_q))
    else $error("read frame modified a register");
  AST_GAIN_ALL: assert property (@(posedge mclk) disable iff (!rstn || soft_rst)
    wr_go && frm.sel == SEL_GAIN_ALL |=> gain_q[0] == ($past(frm.data) & 16'hFFF0) && gain_q[3] == gain_q[0])
    else $error("gain broadcast not applied to all channels");
  AST_USER_TOGGLE: assert property (@(posedge mclk) disable iff (!rstn || soft_rst)
    wr_go && frm.sel == SEL_CTRL && csub == CSUB_SOFT && frm.data[SOFT_TOGGLE] |=> user_q != $past(user_q))
    else $error("user bit did not toggle");
  AST_CODE_FIELD: assert property (@(posedge mclk) disable iff (!rstn)
    code_q[0][3:0] == 4'h0 && clr_q[1][3:0] == 4'h0)
    else $error("code register low bits not zero");
  AST_FRAME_LEN: assert property (@(posedge mclk) disable iff (!rstn)
    wr_go |-> cnt_q == (main_cfg[MAIN_PEC] ? 6'(PEC_BITS) : 6'(FRAME_BITS)))
    else $error("write accepted with wrong frame length");
  AST_STATUS_RETURN: assert property (@(posedge mclk) disable iff (!rstn)
    s_status_write |=> rd_word_q == {8'h00, $past(stat_q)})
    else $error("status word not loaded on write");
  AST_SOFT_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    soft_rst |=> main_q == REG_RST && boost_q == REG_RST && gain_q[2] == GAIN_RST)
    else $error("software reset left a register set");
  AST_DRIVE_OFF: assert property (@(posedge mclk) disable iff (!rstn)
    !chctl_q[3][CH_OUTPUT_DRIVE_ENABLE] && !main_q[MAIN_OUTALL] |=> !chan_out[3].drive_en)
    else $error("output driven without enable");
  AST_SLEW_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
    wr_go && frm.sel == SEL_CTRL && csub == CSUB_SLEW && frm.ch == 2'h1
    |=> slew_q[1] == {3'h0, $past(frm.data[12:0])})
    else $error("slew register write lost");
  AST_CLEAR_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
    wr_go && frm.sel == SEL_CLR && frm.ch == 2'h2 |=> clr_q[2] == ($past(frm.data) & 16'hFFF0))
    else $error("clear code write lost");
  AST_RANGE_COPY: assert property (@(posedge mclk) disable iff (!rstn)
    !soft_rst |=> chan_out[1].range == $past(chctl_q[1][CH_RANGE_LSB +: 2]))
    else $error("range field not passed to channel 1");
endmodule // qdac_serial_ctrl
`default_nettype wire

// ===== verif/qdac_host_model.sv
// qdac_host_model: host serial port that frames words onto the link
`default_nettype none
module qdac_host_model (
  output logic sclk, // serial clock, idles high
  output logic sync_n, // frame select, active low
  output logic sdin, // serial data to the device
  input wire logic sdo // readback data from the device
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS = 40;
  logic [31:0] rx_q;
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b1;
    rx_q = '0;
  end
  // ==========================================
  // frame transfer
  // msb first, whole frame
  task automatic send(input logic [31:0] word, input int nbits);
    #(17);
    sync_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdin = word[i];
      #(HALF_NS);
      sclk = 1'b0;
      #(HALF_NS);
      sclk = 1'b1;
      rx_q = {rx_q[30:0], sdo};
    end
    #(HALF_NS);
    sync_n = 1'b1;
    // released line shows the inverse level
    sdin = ~sdin;
  endtask
endmodule // qdac_host_model
`default_nettype wire

// ===== verif/test_quad_current_dac_serial_control.sv
// test_quad_current_dac_serial_control: self-checking bench for the serial control block
`default_nettype none
module test_quad_current_dac_serial_control;
  timeunit 1ns;
  timeprecision 1ps;
  import qdac_pkg::*;
  logic mclk, rstn, sclk, sync_n, sdin, load_strobe_n, sdo;
  logic [1:0] dev_addr;
  logic [3:0] fault_in, cal_start, cal_seen;
  qdac_chan_s [3:0] chan_out;
  logic [15:0] boost_cfg, main_cfg, v, a, b, o;
  logic [3:0][15:0] slew_cfg;
  localparam logic [2:0] SELS [3] = '{SEL_GAIN, SEL_OFFS, SEL_CLR};
  int fails = 0;
  int tests_run = 0;
  int c;
  // ==========================================
  // clock, device and host
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  qdac_serial_ctrl dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .load_strobe_n(load_strobe_n), .dev_addr(dev_addr), .fault_in(fault_in), .sdo(sdo), .chan_out(chan_out),
    .cal_start(cal_start), .boost_cfg(boost_cfg), .slew_cfg(slew_cfg), .main_cfg(main_cfg));
  qdac_host_model host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo));
  always @(posedge mclk) cal_seen <= cal_seen | cal_start;
  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  function automatic logic [15:0] creg(input logic [2:0] sub, input logic [12:0] f);
    return {sub, f};
  endfunction
  task automatic fr(input logic rw, input logic [1:0] da, input logic [2:0] sel, input logic [1:0] ch,
    input logic [15:0] d, input int nb);
    logic [23:0] w;
    w = {rw, da, sel, ch, d};
    host.send((nb == 32) ? {w, 8'h5A} : {8'h00, w}, nb);
    settle(12);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [1:0] ch, input logic [15:0] d);
    fr(1'b0, dev_addr, sel, ch, d, 24);
  endtask
  // read then shift out with a reserved write
  task automatic rd(input logic [2:0] sel, input logic [1:0] ch, input logic [15:0] d);
    fr(1'b1, dev_addr, sel, ch, d, 24);
    fr(1'b0, dev_addr, 3'h1, 2'h0, 16'h0000, 24);
    v = host.rx_q[15:0];
  endtask
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'hE001));
    rstn = 1'b0;
    load_strobe_n = 1'b0;
    dev_addr = 2'($urandom());
    fault_in = 4'h0;
    cal_seen = 4'h0;
    settle(12);
    rstn = 1'b1;
    settle(4);
    for (c = 0; c < NCH; c++) check(chan_out[c].drive_en, 1'b0);
    check(main_cfg, REG_RST);
    settle(BOOT_WAIT_CYC);
    rd(SEL_GAIN, 2'h1, 16'h0000);
    check(v, GAIN_RST);
    for (c = 0; c < NCH; c++) begin
      a = 16'($urandom_range(2, 0));
      wr(SEL_CTRL, 2'(c), creg(CSUB_CHAN, 13'h0030 | a[12:0]));
      check(chan_out[c].range, a[1:0]);
      check({chan_out[c].boost_on, chan_out[c].drive_en}, 2'b10);
      b = (c == 0) ? 16'hFFF0 : 16'($urandom());
      cal_seen = 4'h0;
      wr(SEL_CODE, 2'(c), b);
      check(chan_out[c].code, b[15:4]);
      check({chan_out[c].range, chan_out[c].code}, {a[1:0], b[15:4]});
      check(cal_seen, 4'h1 << c);
      rd(SEL_CODE, 2'(c), 16'h0000);
      check(v[15:4], b[15:4]);
    end
    check(chan_out[0].code, 12'hFFF);
    load_strobe_n = 1'b1;
    a = 16'($urandom());
    b = ~a;
    o = {chan_out[3].code, 4'h0};
    wr(SEL_CODE, 2'h3, a);
    wr(SEL_CODE, 2'h3, b);
    check(chan_out[3].code, o[15:4]);
    rd(SEL_CODE, 2'h3, 16'h0000);
    check(v[15:4], b[15:4]);
    load_strobe_n = 1'b0;
    settle(8);
    check(chan_out[3].code, a[15:4]);
    a = 16'($urandom());
    wr(SEL_GAIN_ALL, 2'h0, a);
    b = 16'($urandom());
    wr(SEL_OFFS_ALL, 2'h0, b);
    for (c = 0; c < NCH; c++) begin
      rd(SEL_GAIN, 2'(c), 16'h0000);
      check(v[15:4], a[15:4]);
      rd(SEL_OFFS, 2'(c), 16'h0000);
      check(v[15:4], b[15:4]);
    end
    for (int i = 0; i < 3; i++) begin
      a = 16'($urandom());
      wr(SELS[i], 2'h2, a);
      rd(SELS[i], 2'h2, 16'h0000);
      check(v[15:4], a[15:4]);
    end
    o = {chan_out[1].code, 4'h0};
    b = ~o;
    fr(1'b0, ~dev_addr, SEL_CODE, 2'h1, b, 24);
    fr(1'b0, dev_addr, SEL_CODE, 2'h1, b, 23);
    check(chan_out[1].code, o[15:4]);
    for (c = 0; c < NCH; c++) begin
      a = 16'($urandom());
      wr(SEL_CTRL, 2'(c), creg(CSUB_SLEW, a[12:0]));
      check(slew_cfg[c][12:0], a[12:0]);
    end
    a = 16'($urandom());
    wr(SEL_CTRL, 2'h0, creg(CSUB_BOOST, a[12:0]));
    check(boost_cfg[12:0], a[12:0]);
    wr(SEL_CTRL, 2'h0, creg(CSUB_MAIN, 13'h0C00));
    check(main_cfg[12:0], 13'h0C00);
    for (c = 0; c < NCH; c++) check(chan_out[c].drive_en, 1'b1);
    wr(SEL_CTRL, 2'h0, creg(CSUB_MAIN, 13'h0000));
    settle(CAL_WAIT_CYC);
    wr(SEL_CTRL, 2'h2, creg(CSUB_CHAN, 13'h0070));
    check(chan_out[2].drive_en, 1'b1);
    check(chan_out[1].drive_en, 1'b0);
    wr(SEL_CTRL, 2'h0, creg(CSUB_MAIN, 13'h0200));
    o = {chan_out[0].code, 4'h0};
    b = ~o;
    wr(SEL_CODE, 2'h0, b);
    check(chan_out[0].code, o[15:4]);
    fr(1'b0, dev_addr, SEL_CODE, 2'h0, b, 32);
    check(chan_out[0].code, b[15:4]);
    fr(1'b0, dev_addr, SEL_CTRL, 2'h0, creg(CSUB_MAIN, 13'h1000), 32);
    fault_in = 4'($urandom());
    wr(SEL_CTRL, 2'h0, creg(CSUB_SOFT, 13'h1000));
    wr(SEL_CTRL, 2'h1, creg(CSUB_SLEW, 13'h0000));
    fr(1'b0, dev_addr, 3'h1, 2'h0, 16'h0000, 24);
    check(host.rx_q[4:0], {1'b1, fault_in});
    wr(SEL_CTRL, 2'h0, creg(CSUB_MAIN, 13'h0000));
    rd(SEL_CTRL, 2'h0, creg(CSUB_STAT, 13'h0000));
    check(v[4:0], {1'b1, fault_in});
    wr(SEL_CTRL, 2'h0, creg(CSUB_SOFT, {1'b0, SOFT_RESET_KEY}));
    settle(BOOT_WAIT_CYC);
    check(main_cfg, REG_RST);
    check(chan_out[2].drive_en, 1'b0);
    check(chan_out[0].code, 12'h000);
    rd(SEL_GAIN, 2'h3, 16'h0000);
    check(v, GAIN_RST);
    results();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    results();
  end
endmodule // test_quad_current_dac_serial_control
`default_nettype wire
